// ---- logic/stog_pkg.sv ----
package stog_pkg;
	localparam int STOG_SYNC_STAGES = 2;
	localparam int STOG_CLK_MHZ = 25;
	localparam int STOG_BLOCK_MS = 20;
	localparam int STOG_BLOCK_CYC = STOG_BLOCK_MS * 1000 * STOG_CLK_MHZ;
	localparam int STOG_DEB_CYC = 4;
	localparam logic [2:0] STOG_CODE_NONE = 3'h7;
	localparam logic [2:0] STOG_CODE_EXT = 3'h0;
	localparam logic [2:0] STOG_CODE_MISMATCH = 3'h1;
	localparam logic [2:0] STOG_CODE_SUPPLY = 3'h2;
	localparam logic [2:0] STOG_CODE_INPUT = 3'h3;
	localparam logic [2:0] STOG_CODE_BUFFER = 3'h4;
	localparam logic [7:0] STOG_FAULT_GROUP = 8'h96;
	typedef enum logic [1:0] {
		STOG_ST_POWERUP = 2'b00,
		STOG_ST_INIT = 2'b01,
		STOG_ST_RUN = 2'b10,
		STOG_ST_SAFE = 2'b11
	} stog_state_t;
endpackage : stog_pkg

// ---- logic/stog_sync.sv ----
`timescale 1ns/1ps
module stog_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;

	// Reset to low makes both requests read as dropped, so the gate starts blocked.
	always_comb begin
		meta_nxt = rst ? '0 : async_in;
		sync_nxt = rst ? '0 : meta_r;
	end

	always_ff @(posedge clk) begin
		meta_r <= meta_nxt;
		sync_r <= sync_nxt;
	end

	assign sync_out = sync_r;
endmodule : stog_sync

// ---- logic/stog_gate.sv ----
// Contract
// RL1 - Gate signals pass only while both request inputs are high.
// RL2 - Gating is blocked within twenty milliseconds of any request going low.
// RL3 - Both requests low reports the external request code 150.0.
// RL4 - Exactly one request low reports the mismatch code 150.1, gate blocked.
// RL5 - Supply out of range enters torque off and reports code 150.2.
// RL6 - Input circuit fault enters torque off and reports code 150.3.
// RL7 - Buffer circuit fault enters torque off and reports code 150.4.
// RL8 - From power on the buffer enable stays inactive and gating is blocked.
// RL9 - Gating stays blocked until processor initialisation has finished.
// RL10 - Leaving torque off needs auto reset, both high, run off, no fault.
// RL11 - The safety party drops both request inputs at the same time.
// RL12 - The active fault code is shown on the status display output.
// RL13 - Each request input passes two flip-flops before it is evaluated.
`timescale 1ns/1ps
module stog_gate
	import stog_pkg::*;
#(
	parameter int PWM_CH = 6,
	parameter int DEB_CYC = STOG_DEB_CYC
) (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic TORQUE_OFF_REQ_A,
	input wire logic TORQUE_OFF_REQ_B,
	input wire logic SUPPLY_OUT_OF_RANGE,
	input wire logic INPUT_CIRCUIT_FAULT,
	input wire logic BUFFER_CIRCUIT_FAULT,
	input wire logic INIT_DONE,
	input wire logic RUN_CMD,
	input wire logic AUTO_RESET,
	input wire logic [PWM_CH-1:0] PWM_IN,
	output logic [PWM_CH-1:0] PWM_OUT,
	output logic PWM_BUF_EN_N,
	output logic TORQUE_OFF,
	output logic FAULT_VALID,
	output logic [7:0] FAULT_GROUP,
	output logic [2:0] FAULT_SUB
);
	logic [1:0] req_raw;
	logic [1:0] req_s;
	logic [2:0] flt_raw;
	logic [2:0] flt_s;
	logic req_a;
	logic req_b;
	logic both_hi;
	logic one_lo;
	logic diag_flt;
	logic [2:0] cause;
	logic [7:0] deb_r;
	logic [7:0] deb_nxt;
	logic mis_stable;
	stog_state_t st_r;
	stog_state_t st_nxt;
	logic [PWM_CH-1:0] pwm_r;
	logic [PWM_CH-1:0] pwm_nxt;
	logic buf_en_n_r;
	logic buf_en_n_nxt;
	logic [2:0] code_r;
	logic [2:0] code_nxt;

	assign req_raw = {TORQUE_OFF_REQ_B, TORQUE_OFF_REQ_A};
	assign flt_raw = {BUFFER_CIRCUIT_FAULT, INPUT_CIRCUIT_FAULT,
		SUPPLY_OUT_OF_RANGE};

	// Requests and diagnostic flags are resynchronised to the core clock.
	stog_sync #(.WIDTH(2)) u_req_sync ( // RL13
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.async_in(req_raw),
		.sync_out(req_s)
	);

	stog_sync #(.WIDTH(3)) u_flt_sync (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.async_in(flt_raw),
		.sync_out(flt_s)
	);

	assign req_a = req_s[0];
	assign req_b = req_s[1];
	assign both_hi = req_a & req_b;
	assign one_lo = req_a ^ req_b;
	assign diag_flt = |flt_s;

	// A mismatch is reported only once it has lasted a few cycles, so the
	// small skew between two inputs that drop together is not flagged.
	always_comb begin
		deb_nxt = deb_r;
		if (SYS_RST || !one_lo) begin
			deb_nxt = 8'h00;
		end else if (deb_r < 8'(DEB_CYC)) begin
			deb_nxt = deb_r + 8'h01;
		end
	end
	assign mis_stable = one_lo && (deb_r >= 8'(DEB_CYC)); // RL11

	always_ff @(posedge CORE_CLK) begin
		deb_r <= deb_nxt;
	end

	// Cause priority: diagnosis faults first, then the request pattern.
	always_comb begin
		cause = STOG_CODE_NONE;
		if (flt_s[2]) begin
			cause = STOG_CODE_BUFFER; // RL7
		end else if (flt_s[1]) begin
			cause = STOG_CODE_INPUT; // RL6
		end else if (flt_s[0]) begin
			cause = STOG_CODE_SUPPLY; // RL5
		end else if (!req_a && !req_b) begin
			cause = STOG_CODE_EXT; // RL3
		end else if (mis_stable) begin
			cause = STOG_CODE_MISMATCH; // RL4
		end
	end

	always_comb begin
		st_nxt = st_r;
		code_nxt = code_r;
		unique case (st_r)
			STOG_ST_POWERUP: begin
				st_nxt = STOG_ST_INIT; // RL8
			end
			STOG_ST_INIT: begin
				if (INIT_DONE) begin
					st_nxt = STOG_ST_SAFE; // RL9
				end
			end
			STOG_ST_RUN: begin
				if (!both_hi || diag_flt) begin
					st_nxt = STOG_ST_SAFE; // RL1
				end
			end
			STOG_ST_SAFE: begin
				if (AUTO_RESET && both_hi && !RUN_CMD && !diag_flt) begin
					st_nxt = STOG_ST_RUN; // RL10
				end
			end
		endcase
		// The shown code follows the live cause; any new cause replaces it, and
		// the last code is held while no cause is present until RUN is entered.
		if (cause != STOG_CODE_NONE) begin
			code_nxt = cause; // RL12
		end else if (st_nxt == STOG_ST_RUN) begin
			code_nxt = STOG_CODE_NONE;
		end
		if (SYS_RST) begin
			st_nxt = STOG_ST_POWERUP;
			code_nxt = STOG_CODE_NONE;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		st_r <= st_nxt;
		code_r <= code_nxt;
	end

	// Gate passes only in RUN with both requests high and no diagnosis.
	always_comb begin
		if (st_r == STOG_ST_RUN && both_hi && !diag_flt && !SYS_RST) begin
			pwm_nxt = PWM_IN; // RL1
			buf_en_n_nxt = 1'b0;
		end else begin
			pwm_nxt = '0; // RL2
			buf_en_n_nxt = 1'b1; // RL8
		end
	end

	always_ff @(posedge CORE_CLK) begin
		pwm_r <= pwm_nxt;
		buf_en_n_r <= buf_en_n_nxt;
	end

	assign PWM_OUT = pwm_r;
	assign PWM_BUF_EN_N = buf_en_n_r;
	assign TORQUE_OFF = (st_r != STOG_ST_RUN);
	assign FAULT_VALID = (code_r != STOG_CODE_NONE);
	assign FAULT_GROUP = STOG_FAULT_GROUP;
	assign FAULT_SUB = code_r;

	property p_block_after_drop;
		@(posedge CORE_CLK) disable iff (SYS_RST)
		$fell(req_a) || $fell(req_b) |=> ##[0:2] PWM_BUF_EN_N;
	endproperty
	block_on_drop_a: assert property (p_block_after_drop) // RL2
		else $error("gate not blocked after request drop");

	pass_needs_both_a: assert property ( // RL1
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!PWM_BUF_EN_N |-> $past(both_hi) && $past(st_r == STOG_ST_RUN) &&
		!$past(diag_flt))
		else $error("gate open without both requests");

	ext_code_a: assert property ( // RL3
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!req_a && !req_b && !diag_flt |=> FAULT_SUB == STOG_CODE_EXT)
		else $error("external request code missing");

	sequence s_mismatch_hold;
		(one_lo && !diag_flt) [*6];
	endsequence
	mismatch_code_a: assert property ( // RL4
		@(posedge CORE_CLK) disable iff (SYS_RST)
		s_mismatch_hold |=> FAULT_SUB == STOG_CODE_MISMATCH && PWM_BUF_EN_N)
		else $error("mismatch code missing");

	supply_code_a: assert property ( // RL5
		@(posedge CORE_CLK) disable iff (SYS_RST)
		flt_s == 3'h1 |=> FAULT_SUB == STOG_CODE_SUPPLY && TORQUE_OFF)
		else $error("supply fault not reported");

	input_code_a: assert property ( // RL6
		@(posedge CORE_CLK) disable iff (SYS_RST)
		flt_s[1] && !flt_s[2] |=> FAULT_SUB == STOG_CODE_INPUT && TORQUE_OFF)
		else $error("input circuit fault not reported");

	buffer_code_a: assert property ( // RL7
		@(posedge CORE_CLK) disable iff (SYS_RST)
		flt_s[2] |=> FAULT_SUB == STOG_CODE_BUFFER && TORQUE_OFF)
		else $error("buffer circuit fault not reported");

	init_hold_a: assert property ( // RL9
		@(posedge CORE_CLK) disable iff (SYS_RST)
		st_r == STOG_ST_INIT || st_r == STOG_ST_POWERUP |-> PWM_BUF_EN_N)
		else $error("gate open before init done");

	leave_safe_a: assert property ( // RL10
		@(posedge CORE_CLK) disable iff (SYS_RST)
		$past(st_r) == STOG_ST_SAFE && st_r == STOG_ST_RUN |->
		$past(AUTO_RESET) && !$past(RUN_CMD) && $past(both_hi) &&
		!$past(diag_flt))
		else $error("safe state left without return conditions");

	reset_blocked_a: assert property ( // RL8
		@(posedge CORE_CLK)
		SYS_RST |=> PWM_BUF_EN_N && PWM_OUT == '0)
		else $error("gate open after reset");

	sync_delay_a: assert property ( // RL13
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!$past(SYS_RST) && !$past(SYS_RST, 2) |->
		{flt_s, req_s} == $past({flt_raw, req_raw}, 2))
		else $error("inputs not resynchronised in two stages");

	pwm_follow_a: assert property ( // RL1
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!PWM_BUF_EN_N |-> PWM_OUT == $past(PWM_IN))
		else $error("open gate does not follow its input");

	any_low_blocks_a: assert property ( // RL1
		@(posedge CORE_CLK) disable iff (SYS_RST)
		!both_hi |=> PWM_BUF_EN_N && PWM_OUT == '0)
		else $error("gate open with a request low");

	diag_blocks_a: assert property ( // RL5 RL6 RL7
		@(posedge CORE_CLK) disable iff (SYS_RST)
		diag_flt |=> PWM_BUF_EN_N && PWM_OUT == '0 && TORQUE_OFF)
		else $error("gate open during a diagnosis fault");

	code_follow_a: assert property ( // RL12
		@(posedge CORE_CLK) disable iff (SYS_RST)
		cause != STOG_CODE_NONE |=>
		FAULT_SUB == $past(cause) && FAULT_VALID)
		else $error("shown code does not follow the cause");

	run_no_code_a: assert property ( // RL12
		@(posedge CORE_CLK) disable iff (SYS_RST)
		st_r == STOG_ST_RUN |-> !FAULT_VALID &&
		FAULT_GROUP == STOG_FAULT_GROUP)
		else $error("fault code shown while running");

	init_wait_a: assert property ( // RL9
		@(posedge CORE_CLK) disable iff (SYS_RST)
		st_r == STOG_ST_INIT && !INIT_DONE |=> st_r == STOG_ST_INIT)
		else $error("init left before it finished");

	sequence s_reset_release;
		$fell(SYS_RST);
	endsequence
	sequence s_gate_shut_two;
		(PWM_BUF_EN_N && TORQUE_OFF) ##1 (PWM_BUF_EN_N && TORQUE_OFF);
	endsequence
	powerup_hold_a: assert property ( // RL8
		@(posedge CORE_CLK)
		s_reset_release |-> s_gate_shut_two)
		else $error("gate opened right after power on");

	sequence s_return_ok;
		st_r == STOG_ST_SAFE && AUTO_RESET && both_hi && !RUN_CMD &&
		!diag_flt;
	endsequence
	return_run_a: assert property ( // RL10
		@(posedge CORE_CLK) disable iff (SYS_RST)
		s_return_ok |=> !TORQUE_OFF)
		else $error("safe state kept although return was allowed");

	deb_bound_a: assert property ( // RL4
		@(posedge CORE_CLK) disable iff (SYS_RST)
		deb_r <= 8'(DEB_CYC))
		else $error("mismatch counter ran past its limit");

	sequence s_short_skew;
		(st_r == STOG_ST_RUN && both_hi) ##1 one_lo [*2];
	endsequence
	skew_quiet_a: assert property ( // RL4
		@(posedge CORE_CLK) disable iff (SYS_RST)
		s_short_skew |=> FAULT_SUB != STOG_CODE_MISMATCH)
		else $error("short skew reported as mismatch");
endmodule : stog_gate

// ---- testbench/stog_safety_ctl.sv ----
`timescale 1ns/1ps
module stog_safety_ctl (
	input wire logic clk,
	input wire logic stop_all,
	input wire logic stop_a,
	output logic req_a,
	output logic req_b
);
	// A full stop opens both channels at the same instant.
	always_comb begin
		req_a = !(stop_all || stop_a);
		req_b = !stop_all;
	end
endmodule : stog_safety_ctl

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import stog_pkg::*;
	logic clk = 0, rst = 1, init_done = 0, run_cmd = 0, auto_rst = 0;
	logic stop_all = 0, stop_a = 0, req_a, req_b;
	logic [2:0] diag = 3'h0;
	logic [5:0] pwm_in = 6'h2d, pwm_out;
	logic buf_en_n, torque_off, fault_valid;
	logic [7:0] fault_group;
	logic [2:0] fault_sub;
	int num_errors = 0;
	int n_tests = 0;
	stog_gate i_dut (.CORE_CLK(clk), .SYS_RST(rst),
		.TORQUE_OFF_REQ_A(req_a), .TORQUE_OFF_REQ_B(req_b),
		.SUPPLY_OUT_OF_RANGE(diag[0]), .INPUT_CIRCUIT_FAULT(diag[1]),
		.BUFFER_CIRCUIT_FAULT(diag[2]), .INIT_DONE(init_done),
		.RUN_CMD(run_cmd), .AUTO_RESET(auto_rst), .PWM_IN(pwm_in),
		.PWM_OUT(pwm_out), .PWM_BUF_EN_N(buf_en_n),
		.TORQUE_OFF(torque_off), .FAULT_VALID(fault_valid),
		.FAULT_GROUP(fault_group), .FAULT_SUB(fault_sub));
	stog_safety_ctl i_ctl (.clk(clk), .stop_all(stop_all),
		.stop_a(stop_a), .req_a(req_a), .req_b(req_b));
	initial begin
		forever #20 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : chk
	task automatic complete_run();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic blocked(input string msg);
		chk(pwm_out === 6'h00 && buf_en_n === 1'b1, msg);
	endtask : blocked
	task automatic to_run();
		auto_rst = 1;
		tick(1);
		auto_rst = 0;
		tick(3);
		chk(torque_off === 1'b0 && buf_en_n === 1'b0, "no run");
		chk(pwm_out === pwm_in && fault_sub === STOG_CODE_NONE, "run");
		chk(fault_valid === 1'b0, "no code");
		pwm_in = ~pwm_in;
		tick(1);
		chk(pwm_out === pwm_in, "follow");
	endtask : to_run
	task automatic t_reset();
		tick(3);
		chk(torque_off === 1'b1 && fault_sub === STOG_CODE_NONE, "rst");
		blocked("reset gate");
		rst = 0;
		tick(6);
		blocked("init gate");
	endtask : t_reset
	task automatic t_release();
		init_done = 1;
		run_cmd = 1;
		tick(2);
		auto_rst = 1;
		tick(1);
		auto_rst = 0;
		tick(4);
		chk(torque_off === 1'b1, "run cmd ignored");
		blocked("refused gate");
		run_cmd = 0;
		to_run();
		chk(fault_group === 8'h96, "group");
	endtask : t_release
	task automatic t_drop(input logic all, input logic [2:0] code);
		stop_all = all;
		stop_a = !all;
		tick(5);
		blocked("drop gate");
		tick(6);
		chk(fault_sub === code && fault_valid === 1'b1, "code");
		auto_rst = 1;
		tick(1);
		auto_rst = 0;
		tick(1);
		chk(torque_off === 1'b1, "drop held");
		stop_all = 0;
		stop_a = 0;
		tick(4);
		to_run();
	endtask : t_drop
	task automatic t_skew();
		stop_a = 1;
		tick(2);
		stop_all = 1;
		tick(8);
		blocked("skew gate");
		chk(fault_sub === STOG_CODE_EXT, "skew code");
		stop_all = 0;
		stop_a = 0;
		tick(4);
		to_run();
	endtask : t_skew
	task automatic t_rerst();
		rst = 1;
		tick(3);
		chk(torque_off === 1'b1 && fault_sub === STOG_CODE_NONE, "rerst");
		blocked("rerst gate");
		rst = 0;
		tick(1);
		blocked("rerst init");
		tick(5);
		to_run();
	endtask : t_rerst
	task automatic t_diag(input int k, input logic [2:0] code);
		diag = 3'h1 | (3'h1 << k);
		tick(6);
		blocked("diag gate");
		chk(torque_off === 1'b1 && fault_sub === code, "diag");
		auto_rst = 1;
		tick(2);
		auto_rst = 0;
		chk(torque_off === 1'b1, "diag held");
		diag = 3'h0;
		tick(4);
		to_run();
	endtask : t_diag
	initial begin
		#(40 * 2000);
		num_errors++;
		complete_run();
	end
	initial begin
		t_reset();
		t_release();
		t_drop(1'b1, STOG_CODE_EXT);
		t_drop(1'b0, STOG_CODE_MISMATCH);
		t_skew();
		t_diag(0, STOG_CODE_SUPPLY);
		t_diag(1, STOG_CODE_INPUT);
		t_diag(2, STOG_CODE_BUFFER);
		t_rerst();
		complete_run();
	end
endmodule : tb_top
